// >>> logic/indirect_addr_pkg.sv
/*
 * Shared constants and types for the indirect operand address generator.
 * Assumes a core with byte-wide memory, 16-bit addresses and 8-bit index registers.
 */
package indirect_addr_pkg;

   // ****************************************
   // widths and reset values
   // ****************************************
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] PAGE_ZERO = 8'h00;
   // low byte of a word pointer sits at the next page-zero address
   localparam logic [7:0] PTR_LO_OFFSET = 8'h01;

   // ****************************************
   // modes and operations
   // ****************************************
   typedef enum logic [1:0] {
      MODE_SHORT_IND = 2'b00,
      MODE_LONG_IND = 2'b01,
      MODE_SHORT_IDX = 2'b10,
      MODE_LONG_IDX = 2'b11
   } ind_mode_t;

   typedef enum logic [3:0] {
      OP_LOAD = 4'h0,
      OP_COMPARE = 4'h1,
      OP_AND = 4'h2,
      OP_OR = 4'h3,
      OP_XOR = 4'h4,
      OP_ADD = 4'h5,
      OP_ADD_CARRY = 4'h6,
      OP_SUB = 4'h7,
      OP_SUB_CARRY = 4'h8,
      OP_BIT_COMPARE = 4'h9
   } alu_op_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PTR_HI = 3'b001,
      ST_PTR_LO = 3'b010,
      ST_OPERAND = 3'b011,
      ST_DONE = 3'b100
   } gen_state_t;

endpackage

// >>> logic/index_adder.sv
/*
 * Unsigned pointer-plus-index adder with optional index.
 * Assumes pointer and index are stable while the result is sampled.
 */
`timescale 1ns/10ps
module index_adder import indirect_addr_pkg::*; #(
   parameter int AW = ADDR_W,
   parameter int IW = DATA_W
) (
   // operands
   input wire logic [AW-1:0] pointer,
   input wire logic [IW-1:0] index,
   input wire logic use_index,
   // result
   output logic [AW-1:0] sum
);
   // carry past the top bit wraps in the 64 Kbyte space
   always_comb begin
      if (use_index) begin
         sum = pointer + {{(AW-IW){1'b0}}, index};
      end else begin
         sum = pointer;
      end
   end
endmodule // index_adder

// >>> logic/indirect_address_generator.sv
/*
 * Operand address generator for indirect and indirect-indexed modes.
 * Assumes memory shows MEM_RDATA while MEM_RD is high, with no stall, and a
 * decoder on the same clock that holds its request until REQ_READY.
 */
// Contract
// - pointer address byte selects page-zero pointer; operand read via pointer
// - short indirect uses byte pointer; operand address within 00 to FF
// - long modes use word pointer spanning full 64 Kbyte space
// - indexed modes add chosen index register to pointer, unsigned
// - short indexed sum ranges 00 to 1FE, carry reaches upper bit
// - every form carries exactly one byte after opcode: the pointer address
// - accepted for load, compare, logic, add/sub with/without carry, bit-compare
`timescale 1ns/10ps
module indirect_address_generator import indirect_addr_pkg::*; #(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   // clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // request from the instruction decoder
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire logic [1:0] REQ_MODE,
   input wire logic [3:0] REQ_OP,
   input wire logic [DW-1:0] REQ_PTR_ADDR,
   input wire logic REQ_USE_Y,
   // index registers
   input wire logic [DW-1:0] INDEX_X,
   input wire logic [DW-1:0] INDEX_Y,
   // memory read port
   output logic MEM_RD,
   output logic [AW-1:0] MEM_ADDR,
   input wire logic [DW-1:0] MEM_RDATA,
   // result
   output logic DONE,
   output logic ILLEGAL_OP,
   output logic [AW-1:0] OPERAND_ADDR,
   output logic [DW-1:0] OPERAND_DATA,
   output logic [3:0] DONE_OP
);

   // ****************************************
   // state
   // ****************************************
   gen_state_t state, next_state;
   ind_mode_t mode, next_mode;
   logic [3:0] op, next_op;
   logic [DW-1:0] ptr_addr, next_ptr_addr;
   logic [DW-1:0] index, next_index;
   logic [AW-1:0] pointer, next_pointer;
   logic [AW-1:0] op_addr, next_op_addr;
   logic [DW-1:0] op_data, next_op_data;
   logic rd, next_rd;
   logic [AW-1:0] rd_addr, next_rd_addr;
   logic done, next_done;
   logic illegal, next_illegal;
   logic [AW-1:0] sum;
   logic op_ok;
   logic take;
   logic is_long;
   logic is_indexed;

   assign is_long = (mode == MODE_LONG_IND) || (mode == MODE_LONG_IDX);
   assign is_indexed = (mode == MODE_SHORT_IDX) || (mode == MODE_LONG_IDX);
   assign op_ok = (REQ_OP <= OP_BIT_COMPARE);
   // only taken from idle; a refused op leaves the sequencer idle and ready
   assign take = REQ_VALID && (state == ST_IDLE) && op_ok;

   index_adder #(.AW(AW), .IW(DW)) u_add (
      .pointer(pointer),
      .index(index),
      .use_index(is_indexed),
      .sum(sum)
   );

   // ****************************************
   // sequencer
   // ****************************************
   always_comb begin
      next_state = state;
      next_mode = mode;
      next_op = op;
      next_ptr_addr = ptr_addr;
      next_index = index;
      case (state)
         ST_IDLE: begin
            if (take) begin
               // single byte after opcode is the only operand consumed
               next_ptr_addr = REQ_PTR_ADDR;
               next_mode = ind_mode_t'(REQ_MODE);
               next_op = REQ_OP;
               next_index = REQ_USE_Y ? INDEX_Y : INDEX_X;
               next_state = ST_PTR_HI;
            end
         end
         ST_PTR_HI: begin
            if (is_long) begin
               next_state = ST_PTR_LO;
            end else begin
               next_state = ST_OPERAND;
            end
         end
         ST_PTR_LO: begin
            next_state = ST_OPERAND;
         end
         ST_OPERAND: begin
            next_state = ST_DONE;
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= ST_IDLE;
         mode <= MODE_SHORT_IND;
         op <= OP_LOAD;
         ptr_addr <= BYTE_RESET;
         index <= BYTE_RESET;
      end else begin
         state <= next_state;
         mode <= next_mode;
         op <= next_op;
         ptr_addr <= next_ptr_addr;
         index <= next_index;
      end
   end

   // ****************************************
   // pointer assembly
   // ****************************************
   always_comb begin
      next_pointer = pointer;
      case (state)
         ST_PTR_HI: begin
            if (is_long) begin
               // first byte of a word pointer is the high half
               next_pointer = {MEM_RDATA, BYTE_RESET};
            end else begin
               next_pointer = {BYTE_RESET, MEM_RDATA};
            end
         end
         ST_PTR_LO: begin
            next_pointer = {pointer[AW-1:DW], MEM_RDATA};
         end
         default: begin
            next_pointer = pointer;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pointer <= ADDR_RESET;
      end else begin
         pointer <= next_pointer;
      end
   end

   // ****************************************
   // memory read port
   // ****************************************
   always_comb begin
      next_rd = 1'b0;
      next_rd_addr = rd_addr;
      case (state)
         ST_IDLE: begin
            if (take) begin
               next_rd = 1'b1;
               next_rd_addr = {PAGE_ZERO, REQ_PTR_ADDR};
            end
         end
         ST_PTR_HI: begin
            if (is_long) begin
               // low byte address wraps inside page zero
               next_rd = 1'b1;
               next_rd_addr = {PAGE_ZERO, ptr_addr + PTR_LO_OFFSET};
            end
         end
         ST_OPERAND: begin
            next_rd = 1'b1;
            next_rd_addr = sum;
         end
         default: begin
            next_rd = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rd <= 1'b0;
         rd_addr <= ADDR_RESET;
      end else begin
         rd <= next_rd;
         rd_addr <= next_rd_addr;
      end
   end

   // ****************************************
   // result
   // ****************************************
   always_comb begin
      next_op_addr = op_addr;
      next_op_data = op_data;
      next_done = 1'b0;
      next_illegal = 1'b0;
      case (state)
         ST_IDLE: begin
            // refused op: one pulse, no read issued
            next_illegal = REQ_VALID && !op_ok;
         end
         ST_OPERAND: begin
            next_op_addr = sum;
         end
         ST_DONE: begin
            next_op_data = MEM_RDATA;
            next_done = 1'b1;
         end
         default: begin
            next_done = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         op_addr <= ADDR_RESET;
         op_data <= BYTE_RESET;
         done <= 1'b0;
         illegal <= 1'b0;
      end else begin
         op_addr <= next_op_addr;
         op_data <= next_op_data;
         done <= next_done;
         illegal <= next_illegal;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign REQ_READY = (state == ST_IDLE);
   assign MEM_RD = rd;
   assign MEM_ADDR = rd_addr;
   assign DONE = done;
   assign ILLEGAL_OP = illegal;
   assign OPERAND_ADDR = op_addr;
   assign OPERAND_DATA = op_data;
   assign DONE_OP = op;

endmodule // indirect_address_generator

// >>> test/iag_asserts.sv
/* checker for the indirect operand address generator ports
   assumes the memory answers while the read strobe is high */
`timescale 1ns/10ps
module iag_chk (
   // watched ports
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic REQ_VALID,
   input wire logic REQ_READY,
   input wire logic [1:0] REQ_MODE,
   input wire logic [3:0] REQ_OP,
   input wire logic [7:0] REQ_PTR_ADDR,
   input wire logic MEM_RD,
   input wire logic [15:0] MEM_ADDR,
   input wire logic [7:0] MEM_RDATA,
   input wire logic DONE,
   input wire logic ILLEGAL_OP,
   input wire logic [15:0] OPERAND_ADDR,
   input wire logic [7:0] OPERAND_DATA,
   input wire logic [3:0] DONE_OP
);
   logic [1:0] mode;
   logic [3:0] op;
   logic [15:0] rd_a;
   wire take = REQ_VALID && REQ_READY && REQ_OP <= 4'h9;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mode <= 2'h0;
         op <= 4'h0;
         rd_a <= 16'h0000;
      end else begin
         mode <= take ? REQ_MODE : mode;
         op <= take ? REQ_OP : op;
         rd_a <= MEM_RD ? MEM_ADDR : rd_a;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   a_ptr_fetch: assert property (take |=> MEM_RD && MEM_ADDR == {8'h00, $past(REQ_PTR_ADDR)})
      else $error("pointer fetch address wrong");
   a_busy_then_done: assert property (take |=> !REQ_READY ##[3:5] DONE)
      else $error("done late or ready while busy");
   a_bad_op: assert property (REQ_VALID && REQ_READY && REQ_OP > 4'h9 |=> ILLEGAL_OP && !MEM_RD)
      else $error("bad op not refused");
   a_word_ptr: assert property (take && REQ_MODE[0] |=> MEM_RD ##1 MEM_RD && MEM_ADDR == {8'h00, $past(MEM_ADDR[7:0]) + 8'h01})
      else $error("word pointer bytes not consecutive");
   a_short_ind: assert property (DONE && mode == 2'b00 |-> OPERAND_ADDR[15:8] == 8'h00)
      else $error("short indirect out of range");
   a_short_idx: assert property (DONE && mode == 2'b10 |-> OPERAND_ADDR <= 16'h01FE)
      else $error("short indexed out of range");
   a_done_op: assert property (DONE |-> DONE_OP == op && !ILLEGAL_OP)
      else $error("done op differs from taken op");
   a_done_addr: assert property (DONE |-> OPERAND_ADDR == rd_a && OPERAND_DATA == $past(MEM_RDATA))
      else $error("operand not the last read");
endmodule // iag_chk
bind indirect_address_generator iag_chk chk (.CLK, .ARST_N, .REQ_VALID, .REQ_READY, .REQ_MODE,
   .REQ_OP, .REQ_PTR_ADDR, .MEM_RD, .MEM_ADDR, .MEM_RDATA, .DONE, .ILLEGAL_OP, .OPERAND_ADDR,
   .OPERAND_DATA, .DONE_OP);

// >>> test/iag_mem.sv
/* memory model showing the read byte while the strobe is high
   assumes a single read port and no stall */
`timescale 1ns/10ps
module iag_mem (
   // read port
   input wire logic CLK,
   input wire logic RD,
   input wire logic [15:0] ADDR,
   output logic [7:0] RDATA
);
   logic [7:0] idle = 8'h5A;
   always @(posedge CLK) begin
      // off-strobe value keeps toggling, so a read sampled off its strobe shows up
      idle <= ~idle;
   end
   // content is a function of the address, so the bench can predict it
   assign RDATA = RD ? ADDR[7:0] ^ ADDR[15:8] ^ 8'hA5 : idle;
endmodule // iag_mem

// >>> test/test_indirect_address_generator.sv
/* bench for the indirect operand address generator
   assumes the memory model and the bound checker beside it */
`timescale 1ns/10ps
module test_indirect_address_generator import indirect_addr_pkg::*;;
   typedef struct {logic [1:0] m; logic [3:0] o; logic [7:0] p; logic y, x, v;
      logic [15:0] e;} row_t;
   logic CLK, ARST_N, REQ_VALID, REQ_READY, REQ_USE_Y, MEM_RD, DONE, ILLEGAL_OP;
   logic [1:0] REQ_MODE;
   logic [3:0] REQ_OP, DONE_OP;
   logic [7:0] REQ_PTR_ADDR, INDEX_X, INDEX_Y, MEM_RDATA, OPERAND_DATA;
   logic [15:0] MEM_ADDR, OPERAND_ADDR, ea;
   int num_errors = 0, checks_done = 0, cycles = 0;
   // index bits x, v: 1 selects 8'hFF, 0 selects 8'h01; e is the operand address
   row_t rows[10] = '{'{0,0,8'h10,0,1,0,16'h00B5}, '{1,1,8'h20,0,0,0,16'h8584},
      '{2,2,8'h5A,0,1,0,16'h01FE}, '{3,3,8'h30,1,0,0,16'h9595},
      '{1,4,8'hFF,0,0,0,16'h5AA5}, '{2,5,8'h5A,1,0,1,16'h01FE},
      '{3,6,8'h40,0,1,0,16'hE6E3}, '{0,7,8'h5A,0,0,0,16'h00FF},
      '{3,8,8'hFF,1,0,1,16'h5BA4}, '{2,9,8'hA5,1,1,0,16'h0001}};
   indirect_address_generator uut (.CLK(CLK), .ARST_N(ARST_N), .REQ_VALID(REQ_VALID),
      .REQ_READY(REQ_READY), .REQ_MODE(REQ_MODE), .REQ_OP(REQ_OP), .REQ_PTR_ADDR(REQ_PTR_ADDR),
      .REQ_USE_Y(REQ_USE_Y), .INDEX_X(INDEX_X), .INDEX_Y(INDEX_Y), .MEM_RD(MEM_RD),
      .MEM_ADDR(MEM_ADDR), .MEM_RDATA(MEM_RDATA), .DONE(DONE), .ILLEGAL_OP(ILLEGAL_OP),
      .OPERAND_ADDR(OPERAND_ADDR), .OPERAND_DATA(OPERAND_DATA), .DONE_OP(DONE_OP));
   iag_mem mem (.CLK(CLK), .RD(MEM_RD), .ADDR(MEM_ADDR), .RDATA(MEM_RDATA));
   initial begin
      CLK = 0;
      forever #2 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         stop_test;
      end
   end
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   // drive one request, end at the falling edge where done or refusal shows
   task automatic run(row_t r);
      ea = r.e;
      @(posedge CLK);
      {REQ_VALID, REQ_MODE, REQ_OP, REQ_PTR_ADDR, REQ_USE_Y} <= {1'b1, r.m, r.o, r.p, r.y};
      INDEX_X <= r.x ? 8'hFF : 8'h01;
      INDEX_Y <= r.v ? 8'hFF : 8'h01;
      // ready is looked at mid-cycle, where it is settled
      @(negedge CLK);
      for (int i = 0; i < 20 && REQ_READY !== 1'b1; i++) @(negedge CLK);
      @(posedge CLK);
      REQ_VALID <= 1'b0;
      @(negedge CLK);
      for (int i = 0; i < 10 && DONE !== 1'b1 && ILLEGAL_OP !== 1'b1; i++) @(negedge CLK);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      {ARST_N, REQ_VALID, REQ_MODE, REQ_OP, REQ_PTR_ADDR, REQ_USE_Y, INDEX_X, INDEX_Y} = 0;
      repeat (20) @(posedge CLK);
      ARST_N <= 1'b1;
      foreach (rows[k]) begin
         run(rows[k]);
         chk("operand_addr", ea, OPERAND_ADDR);
         chk("operand_data", {8'h00, ea[7:0] ^ ea[15:8] ^ 8'hA5}, {8'h00, OPERAND_DATA});
         chk("last_read_addr", ea, MEM_ADDR);
         chk("done", 16'h0001, {15'h0000, DONE});
         chk("done_op", {12'h000, rows[k].o}, {12'h000, DONE_OP});
         chk("ready_at_done", 16'h0001, {15'h0000, REQ_READY});
         $display("test row %0d done", k);
      end
      run('{0, 4'hA, 8'h10, 0, 0, 0, 16'h0000});
      chk("illegal_op", 16'h0001, {15'h0000, ILLEGAL_OP});
      chk("no_read", 16'h0000, {15'h0000, MEM_RD});
      $display("test refused op done");
      @(posedge CLK);
      {REQ_VALID, REQ_OP} <= {1'b1, 4'h0};
      @(posedge CLK);
      {REQ_VALID, ARST_N} <= 2'b00;
      @(negedge CLK);
      chk("ready_in_reset", 16'h0001, {15'h0000, REQ_READY});
      chk("rd_in_reset", 16'h0000, {15'h0000, MEM_RD});
      repeat (2) @(posedge CLK);
      ARST_N <= 1'b1;
      run(rows[2]);
      chk("addr_after_reset", 16'h01FE, OPERAND_ADDR);
      $display("test mid reset done");
      stop_test;
   end
endmodule // test_indirect_address_generator
